// *** design/tid_decoder.sv ***
// TAP instruction decoder with data path selection and storage requests
//
// Contract
// - Eight-bit IR; all ones selects bypass bit
// - All-zeros external test acts as bypass
// - Sample/preload falls back to bypass
// - Identification instruction selects identification register
// - Identification register is 32-bit shift register
// - After reset, identification register is selected
// - Done-erase clears only the completion flag
// - Done-write programs the completion flag
// - Two-wire data instruction selects 72-bit register
// - Two-wire control instruction selects 12-bit register
// - Output-float releases drains, gate drivers low
// - Reset instruction resets the sequencing logic
// - Two instructions force first input low/high
// - Config address and data instructions select registers
// - Config erase and write instructions act
// - Config verify reads back stored data
// - Logic address 109 bits, data 123 bits
// - Logic write and readback instructions act
// - Autoinc init prepares; autoinc write advances address
// - Autoinc readback advances address in the same cycle its load starts
// - Signature read loads, signature write stores
// - Enable, disable programming, program security fuse
// - Bulk erase and supply discharge instructions
// - Capture-IR always loads identification instruction
// - Inputs sampled on TCK rise, TDO on fall
// - Storage operations start at run-test/idle entry
`include "tid_params.svh"
`default_nettype none
module tid_decoder import tid_pkg::*; #(
   parameter logic [`TID_ID_W-1:0] ID_CODE = `TID_ID_CODE,
   parameter int FIFO_DEPTH = `TID_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe,
   output logic output_float,
   output logic dev_reset_req,
   output logic first_digital_input,
   output logic prog_mode,
   output tid_nv_req_s nv_req,
   output logic [`TID_TWI_CTRL_W-1:0] twi_ctrl,
   output logic [`TID_CFG_ADDR_W-1:0] cfg_addr,
   output logic [`TID_CFG_DATA_W-1:0] cfg_data,
   output logic [`TID_LOGIC_ADDR_W-1:0] logic_addr,
   output logic [`TID_LOGIC_DATA_W-1:0] logic_data,
   output logic [`TID_UES_W-1:0] ues_data,
   input wire logic [`TID_CFG_DATA_W-1:0] cfg_rd_data,
   input wire logic [`TID_LOGIC_DATA_W-1:0] logic_rd_data,
   input wire logic [`TID_UES_W-1:0] ues_rd_data,
   input wire logic [`TID_TWI_DATA_W-1:0] twi_rd_data,
   output logic twi_wr_space,
   output logic twi_wr_valid,
   output logic [`TID_TWI_DATA_W-1:0] twi_wr_data,
   input wire logic twi_wr_ready
);
   tid_state_s q;
   tid_state_s d;
   logic rise; // Test clock rising edge seen this cycle
   logic fall; // Test clock falling edge seen this cycle
   tid_path_e path; // Path chosen by the current instruction
   logic [6:0] len; // Length of that path
   logic push; // Two-wire data word leaves on update
   logic [`TID_IR_W-1:0] id_op;

   assign id_op = `TID_OP_IDCODE;

   // Path for each instruction; anything unlisted lands on bypass
   function automatic tid_path_e path_of(input logic [`TID_IR_W-1:0] op);
      unique case (op)
         `TID_OP_IDCODE: path_of = path_id;
         `TID_OP_TWI_DATA: path_of = path_twi_data;
         `TID_OP_TWI_CTRL: path_of = path_twi_ctrl;
         `TID_OP_CFG_ADDR: path_of = path_cfg_addr;
         `TID_OP_CFG_DATA, `TID_OP_CFG_WRITE, `TID_OP_CFG_READBACK: begin
            path_of = path_cfg_data;
         end
         `TID_OP_LOGIC_ADDR: path_of = path_logic_addr;
         `TID_OP_LOGIC_DATA, `TID_OP_LOGIC_WRITE, `TID_OP_LOGIC_READBACK,
         `TID_OP_WRITE_AUTOINC, `TID_OP_READBACK_AUTOINC: begin
            path_of = path_logic_data;
         end
         `TID_OP_USER_SIGNATURE_READ, `TID_OP_UES_WRITE: path_of = path_ues;
         // Bypass, external test, sample and unknown codes
         default: path_of = path_bypass;
      endcase
   endfunction

   // Length in bits of each path
   function automatic logic [6:0] len_of(input tid_path_e p);
      unique case (p)
         path_id: len_of = 7'(`TID_ID_W);
         path_twi_data: len_of = 7'(`TID_TWI_DATA_W);
         path_twi_ctrl: len_of = 7'(`TID_TWI_CTRL_W);
         path_cfg_addr: len_of = 7'(`TID_CFG_ADDR_W);
         path_cfg_data: len_of = 7'(`TID_CFG_DATA_W);
         path_logic_addr: len_of = 7'(`TID_LOGIC_ADDR_W);
         path_logic_data: len_of = 7'(`TID_LOGIC_DATA_W);
         path_ues: len_of = 7'(`TID_UES_W);
         // Bypass, and any code that no path owns
         default: len_of = 7'd1;
      endcase
   endfunction

   // Storage operation of each instruction, started later in idle
   function automatic tid_nvop_e nvop_of(input logic [`TID_IR_W-1:0] op);
      unique case (op)
         `TID_OP_DONE_ERASE: nvop_of = nv_done_erase;
         `TID_OP_DONE_WRITE: nvop_of = nv_done_write;
         `TID_OP_CFG_ERASE: nvop_of = nv_cfg_erase;
         `TID_OP_CFG_WRITE: nvop_of = nv_cfg_write;
         `TID_OP_CFG_READBACK: nvop_of = nv_cfg_readback;
         `TID_OP_LOGIC_WRITE: nvop_of = nv_logic_write;
         `TID_OP_LOGIC_READBACK: nvop_of = nv_logic_readback;
         `TID_OP_WRITE_AUTOINC: nvop_of = nv_write_autoinc;
         `TID_OP_READBACK_AUTOINC: nvop_of = nv_readback_autoinc;
         `TID_OP_USER_SIGNATURE_READ: nvop_of = nv_user_signature_read;
         `TID_OP_UES_WRITE: nvop_of = nv_ues_write;
         `TID_OP_SECURITY: nvop_of = nv_security;
         `TID_OP_BULK_ERASE: nvop_of = nv_bulk_erase;
         `TID_OP_DISCHARGE: nvop_of = nv_discharge;
         default: nvop_of = nv_none;
      endcase
   endfunction

   // Instructions that hold the outputs released while they stand
   function automatic logic floats(input logic [`TID_IR_W-1:0] op);
      unique case (op)
         `TID_OP_OUTPUT_FLOAT, `TID_OP_LOGIC_ADDR, `TID_OP_LOGIC_DATA,
         `TID_OP_LOGIC_WRITE, `TID_OP_SECURITY, `TID_OP_LOGIC_READBACK,
         `TID_OP_DISCHARGE, `TID_OP_CFG_ADDR, `TID_OP_CFG_DATA,
         `TID_OP_CFG_ERASE, `TID_OP_CFG_WRITE, `TID_OP_CFG_READBACK,
         `TID_OP_BULK_ERASE, `TID_OP_PROG_ENABLE, `TID_OP_UES_WRITE: floats = 1'b1;
         default: floats = 1'b0;
      endcase
   endfunction

   // Standard sixteen-state walk, steered by mode select
   function automatic tid_tap_e tap_next(input tid_tap_e s, input logic m);
      unique case (s)
         tap_reset: tap_next = m ? tap_reset : tap_idle;
         tap_idle: tap_next = m ? tap_sel_dr : tap_idle;
         tap_sel_dr: tap_next = m ? tap_sel_ir : tap_cap_dr;
         tap_cap_dr: tap_next = m ? tap_exit1_dr : tap_shift_dr;
         tap_shift_dr: tap_next = m ? tap_exit1_dr : tap_shift_dr;
         tap_exit1_dr: tap_next = m ? tap_upd_dr : tap_pause_dr;
         tap_pause_dr: tap_next = m ? tap_exit2_dr : tap_pause_dr;
         tap_exit2_dr: tap_next = m ? tap_upd_dr : tap_shift_dr;
         tap_upd_dr: tap_next = m ? tap_sel_dr : tap_idle;
         tap_sel_ir: tap_next = m ? tap_reset : tap_cap_ir;
         tap_cap_ir: tap_next = m ? tap_exit1_ir : tap_shift_ir;
         tap_shift_ir: tap_next = m ? tap_exit1_ir : tap_shift_ir;
         tap_exit1_ir: tap_next = m ? tap_upd_ir : tap_pause_ir;
         tap_pause_ir: tap_next = m ? tap_exit2_ir : tap_pause_ir;
         tap_exit2_ir: tap_next = m ? tap_upd_ir : tap_shift_ir;
         tap_upd_ir: tap_next = m ? tap_sel_dr : tap_idle;
      endcase
   endfunction

   // Edges come only from the second synchroniser stage
   assign rise = q.tck_s[1] && !q.tck_prev;
   assign fall = !q.tck_s[1] && q.tck_prev;
   assign path = path_of(q.ir);
   assign len = len_of(path);
   assign push = rise && (q.tap == tap_upd_dr) && (path == path_twi_data);

   // Next state of the whole decoder
   always_comb begin
      d = q;
      d.tck_s = {q.tck_s[0], tck};
      d.tms_s = {q.tms_s[0], tms};
      d.tdi_s = {q.tdi_s[0], tdi};
      d.tck_prev = q.tck_s[1];
      d.dev_rst = 1'b0;
      d.nv.start = 1'b0;
      // Storage operation starts once the controller sits in idle
      if (q.tap == tap_idle && q.op_pend) begin
         d.op_pend = 1'b0;
         d.nv.start = 1'b1;
         // Auto-increment ops step the address with the start
         if (q.nv.op == nv_write_autoinc || q.nv.op == nv_readback_autoinc) begin
            d.logic_addr = q.logic_addr + 1'b1;
         end
      end
      // Mode select and data in taken on the rising test clock
      if (rise) begin
         d.tap = tap_next(q.tap, q.tms_s[1]);
         unique case (q.tap)
            tap_reset: begin
               d.ir = `TID_OP_IDCODE;
               d.prog_mode = 1'b0;
               d.op_pend = 1'b0;
            end
            tap_cap_dr: begin
               d.sr = '0;
               unique case (path)
                  path_id: d.sr[`TID_ID_W-1:0] = ID_CODE;
                  path_twi_data: d.sr[`TID_TWI_DATA_W-1:0] = twi_rd_data;
                  path_twi_ctrl: d.sr[`TID_TWI_CTRL_W-1:0] = q.twi_ctrl;
                  path_cfg_addr: d.sr[`TID_CFG_ADDR_W-1:0] = q.cfg_addr;
                  path_cfg_data: d.sr[`TID_CFG_DATA_W-1:0] = cfg_rd_data;
                  path_logic_addr: d.sr[`TID_LOGIC_ADDR_W-1:0] = q.logic_addr;
                  path_logic_data: d.sr = logic_rd_data;
                  path_ues: d.sr[`TID_UES_W-1:0] = ues_rd_data;
                  path_bypass: d.sr = '0;
               endcase
            end
            tap_shift_dr: begin
               // Data in enters at the far end of the selected length
               d.sr = q.sr >> 1;
               d.sr[len - 7'd1] = q.tdi_s[1];
            end
            tap_upd_dr: begin
               unique case (path)
                  path_twi_ctrl: d.twi_ctrl = q.sr[`TID_TWI_CTRL_W-1:0];
                  path_cfg_addr: d.cfg_addr = q.sr[`TID_CFG_ADDR_W-1:0];
                  path_cfg_data: d.cfg_data = q.sr[`TID_CFG_DATA_W-1:0];
                  path_logic_addr: d.logic_addr = q.sr[`TID_LOGIC_ADDR_W-1:0];
                  path_logic_data: d.logic_data = q.sr;
                  path_ues: d.ues = q.sr[`TID_UES_W-1:0];
                  default: d.ues = q.ues;
               endcase
            end
            tap_cap_ir: d.ir_sh = `TID_OP_IDCODE;
            tap_shift_ir: d.ir_sh = {q.tdi_s[1], q.ir_sh[`TID_IR_W-1:1]};
            tap_upd_ir: begin
               d.ir = q.ir_sh;
               // Immediate instructions act here, storage ops wait
               unique case (q.ir_sh)
                  `TID_OP_PROG_ENABLE: d.prog_mode = 1'b1;
                  `TID_OP_PROG_DISABLE: d.prog_mode = 1'b0;
                  `TID_OP_DEV_RESET: d.dev_rst = 1'b1;
                  `TID_OP_IN_FORCE_LOW: d.first_in = 1'b0;
                  `TID_OP_IN_FORCE_HIGH: d.first_in = 1'b1;
                  `TID_OP_AUTOINC_INIT: d.logic_addr = '0;
                  default: d.first_in = q.first_in;
               endcase
               d.nv.op = nvop_of(q.ir_sh);
               d.op_pend = (nvop_of(q.ir_sh) != nv_none);
            end
            default: d.sr = q.sr;
         endcase
      end
      // Data out moves only on the falling test clock
      if (fall) begin
         d.tdo_oe = (q.tap == tap_shift_dr) || (q.tap == tap_shift_ir);
         if (q.tap == tap_shift_ir) begin
            d.tdo = q.ir_sh[0];
         end else if (q.tap == tap_shift_dr) begin
            d.tdo = q.sr[0];
         end
      end
   end

   // State register; reset leaves the identification path selected
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
         q.tap <= tap_reset;
         q.ir <= `TID_OP_IDCODE;
         q.ir_sh <= `TID_OP_IDCODE;
      end else begin
         q <= d;
      end
   end

   // Two-wire writes are buffered; full buffer drops the word, space shows it
   tid_fifo #(
      .W(`TID_TWI_DATA_W),
      .DEPTH(FIFO_DEPTH)
   ) u_twi_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(push),
      .in_data(q.sr[`TID_TWI_DATA_W-1:0]),
      .in_ready(twi_wr_space),
      .out_valid(twi_wr_valid),
      .out_data(twi_wr_data),
      .out_ready(twi_wr_ready)
   );

   // Outputs, all from the state register
   assign tdo = q.tdo;
   assign tdo_oe = q.tdo_oe;
   assign output_float = floats(q.ir);
   assign dev_reset_req = q.dev_rst;
   assign first_digital_input = q.first_in;
   assign prog_mode = q.prog_mode;
   assign nv_req = q.nv;
   assign twi_ctrl = q.twi_ctrl;
   assign cfg_addr = q.cfg_addr;
   assign cfg_data = q.cfg_data;
   assign logic_addr = q.logic_addr;
   assign logic_data = q.logic_data;
   assign ues_data = q.ues;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_bypass_zero: assert property (rise && q.tap == tap_cap_dr && path == path_bypass
      |=> q.sr == '0) else $error("bypass capture not zero");
   a_unknown_bypass: assert property ((q.ir == 8'h00 || q.ir == 8'h1C || q.ir == 8'hFF
      || q.ir == 8'h5A) |-> path == path_bypass && len == 7'd1)
      else $error("bypass fallback broken");
   a_id_length: assert property (q.ir == id_op |-> path == path_id && len == 7'd32)
      else $error("id path wrong");
   a_reset_selects_id: assert property (rise && q.tap == tap_reset
      |=> q.ir == id_op) else $error("reset did not select id");
   a_ir_capture_id: assert property (rise && q.tap == tap_cap_ir
      |=> q.ir_sh == id_op) else $error("capture-IR value wrong");
   a_float_out: assert property (q.ir == 8'h18 |-> output_float)
      else $error("float not driven");
   a_reset_pulse: assert property (rise && q.tap == tap_upd_ir && q.ir_sh == 8'h22
      |=> dev_reset_req ##1 !dev_reset_req) else $error("reset pulse wrong");
   a_force_input: assert property (rise && q.tap == tap_upd_ir && q.ir_sh == 8'h13
      |=> first_digital_input) else $error("input force high lost");
   a_twi_length: assert property (q.ir == 8'h25 |-> len == 7'd72)
      else $error("two-wire length wrong");
   a_nv_in_idle: assert property (nv_req.start |-> $past(q.tap) == tap_idle
      && !q.op_pend) else $error("storage op outside idle");
   a_tdo_on_fall: assert property ($changed(tdo) |-> $past(fall))
      else $error("data out moved off falling edge");
endmodule
`default_nettype wire

// *** common/tid_params.svh ***
// Instruction codes, register widths, identification value and buffer depth for the TAP decoder
`ifndef TID_PARAMS_SVH
`define TID_PARAMS_SVH

// Instruction register width and codes
`define TID_IR_W 8
`define TID_OP_EXTEST 8'h00
`define TID_OP_LOGIC_ADDR 8'h01
`define TID_OP_LOGIC_DATA 8'h02
`define TID_OP_BULK_ERASE 8'h03
`define TID_OP_LOGIC_WRITE 8'h07
`define TID_OP_SECURITY 8'h09
`define TID_OP_LOGIC_READBACK 8'h0A
`define TID_OP_IN_FORCE_LOW 8'h12
`define TID_OP_IN_FORCE_HIGH 8'h13
`define TID_OP_DISCHARGE 8'h14
`define TID_OP_PROG_ENABLE 8'h15
`define TID_OP_IDCODE 8'h16
`define TID_OP_USER_SIGNATURE_READ 8'h17
`define TID_OP_OUTPUT_FLOAT 8'h18
`define TID_OP_UES_WRITE 8'h1A
`define TID_OP_SAMPLE 8'h1C
`define TID_OP_PROG_DISABLE 8'h1E
`define TID_OP_AUTOINC_INIT 8'h21
`define TID_OP_DEV_RESET 8'h22
`define TID_OP_DONE_ERASE 8'h24
`define TID_OP_TWI_DATA 8'h25
`define TID_OP_TWI_CTRL 8'h26
`define TID_OP_WRITE_AUTOINC 8'h27
`define TID_OP_CFG_READBACK 8'h28
`define TID_OP_CFG_ERASE 8'h29
`define TID_OP_READBACK_AUTOINC 8'h2A
`define TID_OP_CFG_ADDR 8'h2B
`define TID_OP_CFG_DATA 8'h2D
`define TID_OP_CFG_WRITE 8'h2E
`define TID_OP_DONE_WRITE 8'h2F
`define TID_OP_BYPASS 8'hFF

// Data register lengths
`define TID_SR_W 123
`define TID_ID_W 32
`define TID_TWI_DATA_W 72
`define TID_TWI_CTRL_W 12
`define TID_CFG_ADDR_W 8
`define TID_CFG_DATA_W 16
`define TID_LOGIC_ADDR_W 109
`define TID_LOGIC_DATA_W 123
`define TID_UES_W 32

// Arbitrary identification value, no meaning beyond a legal marker bit
`define TID_ID_CODE 32'h0A5C_3001

// Depth of the write buffer toward the two-wire register side
`define TID_FIFO_DEPTH 4

`endif

// *** common/tid_pkg.sv ***
// Types shared by the TAP instruction decoder
`include "tid_params.svh"
`default_nettype none
package tid_pkg;
   // Controller states
   typedef enum logic [3:0] {
      tap_reset, tap_idle, tap_sel_dr, tap_cap_dr, tap_shift_dr, tap_exit1_dr,
      tap_pause_dr, tap_exit2_dr, tap_upd_dr, tap_sel_ir, tap_cap_ir,
      tap_shift_ir, tap_exit1_ir, tap_pause_ir, tap_exit2_ir, tap_upd_ir
   } tid_tap_e;

   // Serial path placed between data in and data out
   typedef enum logic [3:0] {
      path_bypass, path_id, path_twi_data, path_twi_ctrl, path_cfg_addr,
      path_cfg_data, path_logic_addr, path_logic_data, path_ues
   } tid_path_e;

   // Operations on non-volatile storage, started in run-test/idle
   typedef enum logic [3:0] {
      nv_none, nv_cfg_erase, nv_cfg_write, nv_cfg_readback, nv_logic_write,
      nv_logic_readback, nv_write_autoinc, nv_readback_autoinc, nv_user_signature_read,
      nv_ues_write, nv_done_erase, nv_done_write, nv_security, nv_bulk_erase,
      nv_discharge
   } tid_nvop_e;

   // Request to the storage engine
   typedef struct packed {
      tid_nvop_e op;
      logic start;
   } tid_nv_req_s;

   // Whole decoder state
   typedef struct packed {
      logic [1:0] tck_s;
      logic [1:0] tms_s;
      logic [1:0] tdi_s;
      logic tck_prev;
      tid_tap_e tap;
      logic [`TID_IR_W-1:0] ir_sh;
      logic [`TID_IR_W-1:0] ir;
      logic [`TID_SR_W-1:0] sr;
      logic tdo;
      logic tdo_oe;
      logic op_pend;
      tid_nv_req_s nv;
      logic prog_mode;
      logic first_in;
      logic dev_rst;
      logic [`TID_TWI_CTRL_W-1:0] twi_ctrl;
      logic [`TID_CFG_ADDR_W-1:0] cfg_addr;
      logic [`TID_CFG_DATA_W-1:0] cfg_data;
      logic [`TID_LOGIC_ADDR_W-1:0] logic_addr;
      logic [`TID_LOGIC_DATA_W-1:0] logic_data;
      logic [`TID_UES_W-1:0] ues;
   } tid_state_s;
endpackage
`default_nettype wire

// *** design/tid_fifo.sv ***
// Small flip-flop FIFO with valid and ready on both sides
`default_nettype none
module tid_fifo #(
   parameter int W = 72,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   // Storage, pointers and fill count
   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [AW:0] cnt;
   } tid_fifo_s;

   tid_fifo_s q;
   tid_fifo_s d;
   logic push;
   logic pop;

   // Honest flags straight from the count
   assign in_ready = (q.cnt != FULL);
   assign out_valid = (q.cnt != '0);
   assign out_data = q.mem[q.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Pointers wrap at the depth, so any depth works
   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr] = in_data;
         d.wr = (q.wr == LAST) ? '0 : q.wr + 1'b1;
      end
      if (pop) begin
         d.rd = (q.rd == LAST) ? '0 : q.rd + 1'b1;
      end
      if (push && !pop) begin
         d.cnt = q.cnt + 1'b1;
      end else if (pop && !push) begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// *** tb/tid_jtag_host.sv ***
// Behavioural test controller that drives the TAP link
`default_nettype none
module tid_jtag_host (
   input wire logic clk, // Bench clock, used only to place frames in time
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   timeunit 1ns;
   timeprecision 100ps;
   // Link clock stands low between frames
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
      #1.3;
   end
   // One link cycle: mode and data settle while the clock is low
   task automatic step(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #62.5;
      o = tdo; // Read before the rise, well after the falling update
      tck = 1'b1;
      #62.5;
      tck = 1'b0;
   endtask
   // Frames start a quarter period after a clock rise; the 125 ns step keeps
   // that phase, so no link pin ever moves on a sampling edge
   task automatic align();
      @(posedge clk);
      #1.25;
   endtask
   // Five high mode bits reach test-logic-reset, then park in idle
   task automatic reset_walk();
      logic o;
      align();
      repeat (5) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   endtask
   // From idle: sel selects count (1 data, 2 instruction), LSB first
   task automatic scan(input int sel, input int len, input logic [127:0] din,
      output logic [127:0] dout);
      logic o;
      align();
      dout = '0;
      for (int i = 0; i < sel; i++) step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
      step(1'b0, 1'b0, o);
      for (int i = 0; i < len; i++) begin
         step(i == len - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, 1'b0, o);
      step(1'b0, 1'b0, o);
   endtask
endmodule
`default_nettype wire

// *** tb/test_tap_instruction_decoder.sv ***
// Self-checking bench for the TAP instruction decoder
`include "tid_params.svh"
`default_nettype none
module test_tap_instruction_decoder import tid_pkg::*; ;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, rst_n = 1'b0, tck, tms, tdi, tdo, twi_wr_ready = 1'b0;
   logic output_float, dev_reset_req, first_digital_input, prog_mode, tdo_oe;
   logic [31:0] ues_data;
   int n_oe = 0;
   logic twi_wr_space, twi_wr_valid;
   logic [71:0] twi_wr_data;
   tid_nv_req_s nv_req;
   logic [11:0] twi_ctrl;
   logic [7:0] cfg_addr;
   logic [15:0] cfg_data;
   logic [108:0] logic_addr;
   logic [122:0] logic_data;
   logic [127:0] o, w;
   logic [71:0] exp_q[$];
   int seed = 32'h54b8, n_fail = 0, n_compared = 0, n_start = 0, n_rst = 0, n_pop = 0;
   // Codes with storage work, and the request each must raise
   logic [7:0] nv_code[14] = '{8'h29, 8'h2E, 8'h28, 8'h07, 8'h0A, 8'h27, 8'h2A,
      8'h17, 8'h1A, 8'h24, 8'h2F, 8'h09, 8'h03, 8'h14};
   tid_nvop_e nv_op[14] = '{nv_cfg_erase, nv_cfg_write, nv_cfg_readback,
      nv_logic_write, nv_logic_readback, nv_write_autoinc, nv_readback_autoinc,
      nv_user_signature_read, nv_ues_write, nv_done_erase, nv_done_write, nv_security,
      nv_bulk_erase, nv_discharge};
   // Selectable registers and their lengths
   logic [7:0] p_code[6] = '{8'h26, 8'h2B, 8'h2D, 8'h01, 8'h02, 8'h17};
   int p_len[6] = '{12, 8, 16, 109, 123, 32};
   // What each capture loads: register contents, or the tied read data
   logic [127:0] p_cap[6] = '{'0, '0, 128'h3C5A, '0, '0, 128'h1234_5678};
   always #2.5 clk = ~clk;
   tid_jtag_host i_host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
   tid_decoder i_dut (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .output_float(output_float), .dev_reset_req(dev_reset_req),
      .first_digital_input(first_digital_input), .prog_mode(prog_mode),
      .nv_req(nv_req), .twi_ctrl(twi_ctrl), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
      .logic_addr(logic_addr), .logic_data(logic_data), .ues_data(ues_data),
      .cfg_rd_data(16'h3C5A), .logic_rd_data('0), .ues_rd_data(32'h1234_5678),
      .twi_rd_data(~w[71:0]), .twi_wr_space(twi_wr_space), .twi_wr_valid(twi_wr_valid),
      .twi_wr_data(twi_wr_data), .twi_wr_ready(twi_wr_ready));
   // Compare one value and count it
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Instruction load, then let the synchronised effects land
   task automatic ir(input logic [7:0] c);
      i_host.scan(2, 8, {120'h0, c}, o);
      repeat (8) @(posedge clk);
   endtask
   // Selected register value as seen at the ports
   function automatic logic [127:0] port_of(input int k);
      case (k)
         0: return {116'h0, twi_ctrl};
         1: return {120'h0, cfg_addr};
         2: return {112'h0, cfg_data};
         3: return {19'h0, logic_addr};
         5: return {96'h0, ues_data};
         default: return {5'h0, logic_data};
      endcase
   endfunction
   // Pulses and FIFO handshakes are counted as they happen
   always @(posedge clk) begin
      if (nv_req.start === 1'b1) n_start++;
      if (dev_reset_req === 1'b1) n_rst++;
      if (tdo_oe === 1'b1) n_oe++;
      if (twi_wr_valid === 1'b1 && twi_wr_ready === 1'b1) begin
         chk({56'h0, twi_wr_data}, {56'h0, exp_q.pop_front()});
         n_pop++;
      end
   end
   task automatic summarize();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Cuts a hang short well past the expected run length
   initial begin
      #400_000;
      n_fail++;
      summarize();
   end
   initial begin
      int s;
      repeat (10) @(posedge clk);
      @(negedge clk) rst_n = 1'b1;
      repeat (10) @(posedge clk);
      i_host.reset_walk();
      i_host.scan(1, 32, '0, o);
      chk(o, {96'h0, `TID_ID_CODE});
      chk(tdo_oe, 1'b0);
      i_host.scan(2, 8, {120'h0, 8'hFF}, o);
      chk(o, 128'h16);
      ir(8'h16);
      i_host.scan(1, 32, '0, o);
      chk(o, {96'h0, `TID_ID_CODE});
      // Bypass family: one bit of delay behind a captured zero
      for (int k = 0; k < 4; k++) begin
         w = $random(seed);
         ir(k == 0 ? 8'hFF : k == 1 ? 8'h00 : k == 2 ? 8'h1C : {1'b1, w[14:9], 1'b0});
         i_host.scan(1, 8, w, o);
         chk(o, {120'h0, w[6:0], 1'b0});
      end
      for (int k = 0; k < 6; k++) begin
         w = {$random(seed), $random(seed), $random(seed), $random(seed)};
         w = w & ((128'h1 << p_len[k]) - 1);
         ir(p_code[k]);
         i_host.scan(1, p_len[k], w, o);
         chk(o, p_cap[k]);
         repeat (8) @(posedge clk);
         chk(port_of(k), w);
      end
      for (int k = 0; k < 14; k++) begin
         s = n_start;
         ir(nv_code[k]);
         chk(nv_req.op, nv_op[k]);
         chk(n_start, s + 1);
      end
      ir(8'h21);
      chk({19'h0, logic_addr}, 128'h0);
      ir(8'h27);
      chk({19'h0, logic_addr}, 128'h1);
      ir(8'h18);
      chk(output_float, 1'b1);
      ir(8'h16);
      chk(output_float, 1'b0);
      ir(8'h22);
      chk(n_rst, 1);
      ir(8'h13);
      chk(first_digital_input, 1'b1);
      ir(8'h12);
      chk(first_digital_input, 1'b0);
      ir(8'h15);
      chk(prog_mode, 1'b1);
      ir(8'h1E);
      chk(prog_mode, 1'b0);
      // Test-logic-reset cancels programming and reselects the identification path
      ir(8'h15);
      i_host.reset_walk();
      chk(prog_mode, 1'b0);
      i_host.scan(1, 32, '0, o);
      chk(o, {96'h0, `TID_ID_CODE});
      // Five words into four places while the far side stalls
      ir(8'h25);
      for (int k = 0; k < 5; k++) begin
         w = {$random(seed), $random(seed), $random(seed), $random(seed)};
         i_host.scan(1, 72, w, o);
         chk(o, {56'h0, ~w[71:0]});
         if (k < 4) exp_q.push_back(w[71:0]);
      end
      repeat (8) @(posedge clk);
      chk(twi_wr_space, 1'b0);
      chk(twi_wr_valid, 1'b1);
      @(negedge clk) twi_wr_ready = 1'b1;
      repeat (12) @(posedge clk);
      chk(n_pop, 4);
      chk(twi_wr_valid, 1'b0);
      chk(n_oe != 0, 1'b1);
      summarize();
   end
endmodule
`default_nettype wire
